// ---- logic/ddbpl_pkg.sv ----
/*
 * Shared constants for the parallel-load DAC controller: register map,
 * field positions, reset values, pin timing and sequencer states.
 * Assumes a 20 MHz system clock; all times are rounded to whole cycles.
 */
`default_nettype none

package ddbpl_pkg;

    // ********************************************************
    // register map (byte addresses, one word each)
    // ********************************************************
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_CODE   = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;

    // control fields
    localparam int CTRL_GO          = 0;
    localparam int CTRL_BYTE_MODE   = 1;
    localparam int CTRL_TRANSPARENT = 2;
    localparam int CTRL_CLEAR       = 3;
    // status fields
    localparam int STAT_BUSY        = 0;
    localparam int STAT_DONE        = 1;
    localparam int STAT_CLEARING    = 2;
    localparam int STAT_CODE_LSB    = 16;

    localparam int CODE_W = 10;
    localparam logic [CODE_W-1:0] CODE_RESET = 10'h000;
    localparam logic [1:0] SUB_LSB_ZERO = 2'h0;

    // ********************************************************
    // pin timing
    // ********************************************************
    localparam int CLK_PERIOD_NS = 50;
    localparam int SETUP_NS      = 50;
    localparam int WR_PULSE_NS   = 100;
    localparam int DATA_HOLD_NS  = 50;
    localparam int LOAD_PULSE_NS = 100;
    localparam int LOAD_HOLD_NS  = 50;

    localparam int SETUP_CYC = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WR_CYC    = (WR_PULSE_NS + CLK_PERIOD_NS - 1)
                               / CLK_PERIOD_NS;
    localparam int HOLD_CYC  = (DATA_HOLD_NS + CLK_PERIOD_NS - 1)
                               / CLK_PERIOD_NS;
    localparam int LOAD_CYC  = (LOAD_PULSE_NS + CLK_PERIOD_NS - 1)
                               / CLK_PERIOD_NS;
    localparam int LOAD_HOLD_CYC = (LOAD_HOLD_NS + CLK_PERIOD_NS - 1)
                                   / CLK_PERIOD_NS;

    localparam int TIMER_W = 4;

    // ********************************************************
    // sequencer states, gray coded along the write path
    // ********************************************************
    typedef enum logic [2:0] {
        ST_IDLE   = 3'h0,
        ST_SETUP  = 3'h1,
        ST_STROBE = 3'h3,
        ST_HOLD   = 3'h2,
        ST_LOAD   = 3'h6
    } ddbpl_state_t;

endpackage : ddbpl_pkg

`default_nettype wire

// ---- logic/ddbpl_timer.sv ----
/*
 * Down-counter that times each phase of the pin sequence.
 * Assumes the caller loads it with the phase length minus one.
 */
`timescale 1ns/100ps
`default_nettype none

module ddbpl_timer
    import ddbpl_pkg::*;
#(
    parameter int W = TIMER_W
) (
    input  wire logic         clk_sys,
    input  wire logic         srst,
    input  wire logic         load,
    input  wire logic [W-1:0] loadValue,
    output logic              expired
);

    logic [W-1:0] count;
    logic [W-1:0] next_count;

    always_comb begin
        if (load) begin
            next_count = loadValue;
        end else if (count != '0) begin
            next_count = count - 1'b1;
        end else begin
            next_count = count;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            count <= '0;
        end else begin
            count <= next_count;
        end
    end

    assign expired = (count == '0);

endmodule : ddbpl_timer

`default_nettype wire

// ---- logic/ddbpl_host.sv ----
/*
 * Host-side controller for a double-buffered parallel-load DAC.
 * Software writes a 10-bit code over APB and starts a load; the
 * sequencer drives chip select, write, nibble selects, data pins,
 * load strobe and clear of the converter.
 * Assumes the converter's data pins are wired as dacDataPins[3:0] to
 * the shared low group and dacDataPins[7:4] to the D2..D5 group; with a
 * 4-bit wiring both groups carry the same nibble.
 */
// Added by the designer: the register offsets and the APB register port.
`timescale 1ns/100ps
`default_nettype none

// Contract
// - Load strobe lowered by write rise stays low 50ns after.
// - Host writes zeros into both sub-LSB positions.
// - 4-bit host parallels low pins with D2..D5, three nibble writes.
// - With strobe high, high nibble and byte in any order, then pulse.
// - Strobe held low: byte first, then high nibble, two cycles.
module ddbpl_host
    import ddbpl_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input  wire logic              clk_sys,
    input  wire logic              srst,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    output logic                   dacChipSelectN,
    output logic                   dacWriteN,
    output logic                   dacLoadStrobeN,
    output logic                   latchClearN,
    output logic                   nibbleSelectFirst,
    output logic                   nibbleSelectSecond,
    output logic      [7:0]        dacDataPins
);

    // ********************************************************
    // pin pattern for one write step
    // ********************************************************
    // returns {first select, second select, eight data pins}
    function automatic logic [9:0] stepPins(input logic [1:0]  step,
                                            input logic        byteMode,
                                            input logic [11:0] word);
        logic [3:0] nib;
        nib = 4'h0;
        if (byteMode) begin
            if (step == 2'h0) begin
                stepPins = {2'b00, word[7:0]};
            end else begin
                nib = word[11:8];
                stepPins = {2'b11, nib, nib};
            end
        end else begin
            case (step)
                2'h0: begin
                    nib = word[3:0];
                    stepPins = {2'b01, nib, nib};
                end
                2'h1: begin
                    nib = word[7:4];
                    stepPins = {2'b10, nib, nib};
                end
                default: begin
                    nib = word[11:8];
                    stepPins = {2'b11, nib, nib};
                end
            endcase
        end
    endfunction : stepPins

    // ********************************************************
    // register file
    // ********************************************************
    logic                ctrlByteMode;
    logic                ctrlTransparent;
    logic                ctrlClear;
    logic [CODE_W-1:0]   codeReg;
    logic                doneFlag;
    logic                goPulse;
    logic                next_ctrlByteMode;
    logic                next_ctrlTransparent;
    logic                next_ctrlClear;
    logic [CODE_W-1:0]   next_codeReg;
    logic                next_doneFlag;
    logic                next_goPulse;
    logic [31:0]         next_prdata;
    logic                next_pready;
    logic                next_pslverr;

    logic                busy;
    logic                finishEvent;
    logic [CODE_W-1:0]   lastCode;
    logic                accessEdge;
    logic                wrAccess;
    logic                mapped;
    logic [7:0]          regAddr;

    assign regAddr    = 8'(paddr);
    assign accessEdge = psel & penable & pready;
    assign wrAccess   = accessEdge & pwrite;
    assign mapped     = (regAddr == REG_CTRL) || (regAddr == REG_CODE)
                        || (regAddr == REG_STATUS);

    always_comb begin
        next_ctrlByteMode    = ctrlByteMode;
        next_ctrlTransparent = ctrlTransparent;
        next_ctrlClear       = ctrlClear;
        next_codeReg         = codeReg;
        next_goPulse         = 1'b0;
        next_doneFlag        = doneFlag;
        next_prdata          = prdata;
        // one wait state: ready rises in the second access cycle
        next_pready          = psel & penable & ~pready;
        next_pslverr         = psel & penable & ~pready & ~mapped;
        if (psel && penable && !pready) begin
            next_prdata = 32'h0;
            case (regAddr)
                REG_CTRL: begin
                    next_prdata[CTRL_BYTE_MODE]   = ctrlByteMode;
                    next_prdata[CTRL_TRANSPARENT] = ctrlTransparent;
                    next_prdata[CTRL_CLEAR]       = ctrlClear;
                end
                REG_CODE: begin
                    next_prdata[CODE_W-1:0] = codeReg;
                end
                REG_STATUS: begin
                    next_prdata[STAT_BUSY]     = busy;
                    next_prdata[STAT_DONE]     = doneFlag;
                    next_prdata[STAT_CLEARING] = ~latchClearN;
                    next_prdata[STAT_CODE_LSB +: CODE_W] = lastCode;
                end
                default: begin
                    next_prdata = 32'h0;
                end
            endcase
        end
        if (wrAccess) begin
            case (regAddr)
                REG_CTRL: begin
                    next_ctrlByteMode    = pwdata[CTRL_BYTE_MODE];
                    next_ctrlTransparent = pwdata[CTRL_TRANSPARENT];
                    next_ctrlClear       = pwdata[CTRL_CLEAR];
                    next_goPulse         = pwdata[CTRL_GO];
                end
                REG_CODE: begin
                    next_codeReg = pwdata[CODE_W-1:0];
                end
                REG_STATUS: begin
                    if (pwdata[STAT_DONE]) begin
                        next_doneFlag = 1'b0;
                    end
                end
                default: begin
                    next_codeReg = codeReg;
                end
            endcase
        end
        // a finish in the clearing cycle is not lost
        if (finishEvent) begin
            next_doneFlag = 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            ctrlByteMode    <= 1'b0;
            ctrlTransparent <= 1'b0;
            ctrlClear       <= 1'b0;
            codeReg         <= CODE_RESET;
            doneFlag        <= 1'b0;
            goPulse         <= 1'b0;
            prdata          <= 32'h0;
            pready          <= 1'b0;
            pslverr         <= 1'b0;
        end else begin
            ctrlByteMode    <= next_ctrlByteMode;
            ctrlTransparent <= next_ctrlTransparent;
            ctrlClear       <= next_ctrlClear;
            codeReg         <= next_codeReg;
            doneFlag        <= next_doneFlag;
            goPulse         <= next_goPulse;
            prdata          <= next_prdata;
            pready          <= next_pready;
            pslverr         <= next_pslverr;
        end
    end

    // ********************************************************
    // pin sequencer
    // ********************************************************
    ddbpl_state_t        state;
    ddbpl_state_t        next_state;
    logic [1:0]          step;
    logic [1:0]          next_step;
    logic [11:0]         word;
    logic [11:0]         next_word;
    logic                seqByte;
    logic                seqTransp;
    logic                next_seqByte;
    logic                next_seqTransp;
    logic [CODE_W-1:0]   next_lastCode;
    logic                next_csN;
    logic                next_wrN;
    logic                next_loadN;
    logic [9:0]          next_pins;
    logic                timerLoad;
    logic [TIMER_W-1:0]  timerValue;
    logic                expired;
    logic [9:0]          firstPins;
    logic [9:0]          followPins;
    logic [1:0]          lastStep;

    ddbpl_timer #(
        .W (TIMER_W)
    ) u_timer (
        .clk_sys   (clk_sys),
        .srst      (srst),
        .load      (timerLoad),
        .loadValue (timerValue),
        .expired   (expired)
    );

    assign busy       = (state != ST_IDLE);
    // sub-LSBs always zero so the code lands in the upper ten bits
    assign firstPins  = stepPins(2'h0, ctrlByteMode,
                                 {codeReg, SUB_LSB_ZERO});
    assign followPins = stepPins(step + 2'h1, seqByte, word);
    assign lastStep   = seqByte ? 2'h1 : 2'h2;

    always_comb begin
        next_state     = state;
        next_step      = step;
        next_word      = word;
        next_seqByte   = seqByte;
        next_seqTransp = seqTransp;
        next_lastCode  = lastCode;
        next_csN       = dacChipSelectN;
        next_wrN       = dacWriteN;
        next_loadN     = dacLoadStrobeN;
        next_pins      = {nibbleSelectFirst, nibbleSelectSecond,
                          dacDataPins};
        timerLoad      = 1'b0;
        timerValue     = '0;
        finishEvent    = 1'b0;
        case (state)
            ST_IDLE: begin
                if (goPulse) begin
                    next_state     = ST_SETUP;
                    next_step      = 2'h0;
                    next_word      = {codeReg, SUB_LSB_ZERO};
                    next_seqByte   = ctrlByteMode;
                    next_seqTransp = ctrlTransparent;
                    next_pins      = firstPins;
                    next_csN       = 1'b0;
                    // strobe low through the writes makes it transparent
                    next_loadN     = ~ctrlTransparent;
                    timerLoad      = 1'b1;
                    timerValue     = TIMER_W'(SETUP_CYC - 1);
                end
            end
            ST_SETUP: begin
                if (expired) begin
                    next_state = ST_STROBE;
                    next_wrN   = 1'b0;
                    timerLoad  = 1'b1;
                    timerValue = TIMER_W'(WR_CYC - 1);
                end
            end
            ST_STROBE: begin
                if (expired) begin
                    next_state = ST_HOLD;
                    next_wrN   = 1'b1;
                    timerLoad  = 1'b1;
                    timerValue = TIMER_W'(HOLD_CYC - 1);
                end
            end
            ST_HOLD: begin
                if (expired) begin
                    timerLoad = 1'b1;
                    if (step == lastStep) begin
                        next_state = ST_LOAD;
                        next_csN   = 1'b1;
                        // copy with chip select high, or keep strobe
                        // low long enough after the last write rise
                        next_loadN = 1'b0;
                        timerValue = seqTransp
                            ? TIMER_W'(LOAD_HOLD_CYC - 1)
                            : TIMER_W'(LOAD_CYC - 1);
                    end else begin
                        next_state = ST_SETUP;
                        next_step  = step + 2'h1;
                        next_csN   = 1'b0;
                        next_pins  = followPins;
                        timerValue = TIMER_W'(SETUP_CYC - 1);
                    end
                end
            end
            ST_LOAD: begin
                if (expired) begin
                    // rising strobe is where the converter keeps the word
                    next_state    = ST_IDLE;
                    next_loadN    = 1'b1;
                    next_lastCode = word[11:2];
                    finishEvent   = 1'b1;
                end
            end
            default: begin
                next_state = ST_IDLE;
                next_csN   = 1'b1;
                next_wrN   = 1'b1;
                next_loadN = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            state              <= ST_IDLE;
            step               <= 2'h0;
            word               <= 12'h000;
            seqByte            <= 1'b0;
            seqTransp          <= 1'b0;
            lastCode           <= CODE_RESET;
            dacChipSelectN     <= 1'b1;
            dacWriteN          <= 1'b1;
            dacLoadStrobeN     <= 1'b1;
            // clear asserted during reset zeroes the converter too
            latchClearN        <= 1'b0;
            nibbleSelectFirst  <= 1'b0;
            nibbleSelectSecond <= 1'b0;
            dacDataPins        <= 8'h00;
        end else begin
            state              <= next_state;
            step               <= next_step;
            word               <= next_word;
            seqByte            <= next_seqByte;
            seqTransp          <= next_seqTransp;
            lastCode           <= next_lastCode;
            dacChipSelectN     <= next_csN;
            dacWriteN          <= next_wrN;
            dacLoadStrobeN     <= next_loadN;
            latchClearN        <= ~ctrlClear;
            nibbleSelectFirst  <= next_pins[9];
            nibbleSelectSecond <= next_pins[8];
            dacDataPins        <= next_pins[7:0];
        end
    end

endmodule : ddbpl_host

`default_nettype wire

// ---- verification/ddbpl_dac_model.sv ----
/*
 * Behavioural model of the converter's double-buffered parallel latches.
 * Assumes the pin wiring given at the controller's dacDataPins port.
 */
`timescale 1ns/100ps
`default_nettype none

// *****
// latch model
// *****
module ddbpl_dac_model (
    input  wire logic        csN,
    input  wire logic        wrN,
    input  wire logic        loadN,
    input  wire logic        clearN,
    input  wire logic        selFirst,
    input  wire logic        selSecond,
    input  wire logic [7:0]  pins,
    output logic      [11:0] inLatch,
    output logic      [11:0] dacLatch,
    output logic             holdErr
);
    realtime wrRise;
    logic    lowAtRise;

    initial begin
        inLatch  = 12'h000;
        dacLatch = 12'h000;
        holdErr  = 1'b0;
        wrRise   = 0;
    end

    // level sensitive: follows the pins while both strobes stay low
    always @* begin
        if (!csN && !wrN) begin
            case ({selFirst, selSecond})
                2'b11:   inLatch[11:8] = pins[3:0];
                2'b10:   inLatch[7:4]  = pins[7:4];
                2'b01:   inLatch[3:0]  = pins[3:0];
                default: inLatch[7:0]  = pins;
            endcase
        end
    end

    // transparent while the strobe is low, holds from its rising edge
    always @* begin
        if (!clearN) dacLatch = 12'h000;
        else if (!loadN) dacLatch = inLatch;
    end

    always @(posedge wrN) begin
        wrRise    = $realtime;
        lowAtRise = !loadN;
    end

    // a strobe released too soon after the write edge may latch stale data
    always @(posedge loadN) begin
        if (lowAtRise && ($realtime - wrRise < 50.0)) holdErr = 1'b1;
    end
endmodule : ddbpl_dac_model

`default_nettype wire

// ---- verification/ddbpl_host_asserts.sv ----
/*
 * Pin and register checks for the parallel-load controller.
 * Assumes it is bound to ddbpl_host and sees only its ports.
 */
`timescale 1ns/100ps
`default_nettype none

// *****
// checker
// *****
module ddbpl_host_asserts
    import ddbpl_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input wire logic              clk_sys,
    input wire logic              srst,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [31:0]       pwdata,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire logic              dacChipSelectN,
    input wire logic              dacWriteN,
    input wire logic              dacLoadStrobeN,
    input wire logic              latchClearN,
    input wire logic              nibbleSelectFirst,
    input wire logic              nibbleSelectSecond,
    input wire logic [7:0]        dacDataPins
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (srst);

    wr_needs_cs_a:
        assert property (!dacWriteN |-> !dacChipSelectN)
        else $error("write strobe low without chip select");
    sub_lsb_zero_a:
        assert property (!dacWriteN && !nibbleSelectFirst
                         |-> dacDataPins[1:0] == SUB_LSB_ZERO)
        else $error("sub-lsb pins not zero during low write");
    wr_pulse_a:
        assert property ($fell(dacWriteN) |=> !dacWriteN ##1 dacWriteN)
        else $error("write strobe not two cycles low");
    pins_steady_a:
        assert property (!dacWriteN |-> $stable(dacDataPins)
            && $stable(nibbleSelectFirst) && $stable(nibbleSelectSecond))
        else $error("data or selects moved under write strobe");
    write_hold_a:
        assert property ($rose(dacWriteN)
                         |-> !dacChipSelectN && $stable(dacDataPins))
        else $error("data or chip select not held after write");
    load_hold_a:
        assert property ($rose(dacWriteN) && !dacLoadStrobeN
                         |=> !dacLoadStrobeN)
        else $error("load strobe released too soon after write");
    load_pulse_a:
        assert property ($fell(dacLoadStrobeN) && dacChipSelectN
            |=> !dacLoadStrobeN && dacWriteN ##1 dacLoadStrobeN)
        else $error("load pulse not two cycles");
    clear_follow_a:
        assert property (psel && penable && pready && pwrite
            && paddr == ADDR_W'(REG_CTRL)
            |-> ##2 latchClearN == !$past(pwdata[CTRL_CLEAR], 2))
        else $error("clear pin does not follow control bit");
endmodule : ddbpl_host_asserts

bind ddbpl_host ddbpl_host_asserts #(.ADDR_W(ADDR_W)) chk (
    .clk_sys(clk_sys), .srst(srst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .dacChipSelectN(dacChipSelectN), .dacWriteN(dacWriteN),
    .dacLoadStrobeN(dacLoadStrobeN), .latchClearN(latchClearN),
    .nibbleSelectFirst(nibbleSelectFirst),
    .nibbleSelectSecond(nibbleSelectSecond), .dacDataPins(dacDataPins)
);

`default_nettype wire

// ---- verification/dac_double_buffered_parallel_load_tb_top.sv ----
/*
 * Self-checking bench: APB tasks drive the controller, the latch model
 * stands in for the converter.  Assumes a 20 MHz clock.
 */
`timescale 1ns/100ps
`default_nettype none

// *****
// bench
// *****
module dac_double_buffered_parallel_load_tb_top;
    import ddbpl_pkg::*;
    logic        clk_sys = 1'b0;
    logic        srst    = 1'b1;
    logic [7:0]  paddr   = 8'h00;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [31:0] pwdata  = 32'h0;
    logic [31:0] prdata, rd;
    logic        pready, pslverr, rdErr, holdErr;
    logic        dacChipSelectN, dacWriteN, dacLoadStrobeN, latchClearN;
    logic        nibbleSelectFirst, nibbleSelectSecond;
    logic [7:0]  dacDataPins;
    logic [11:0] inLatch, dacLatch;
    logic [31:0] ctrlTab [4] = '{32'h3, 32'h1, 32'h7, 32'h5};
    logic [9:0]  codeTab [4] = '{10'h2a5, 10'h15a, 10'h3ff, 10'h001};
    int          num_errors = 0;
    int          n_checks   = 0;

    ddbpl_host uut (
        .clk_sys(clk_sys), .srst(srst), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .dacChipSelectN(dacChipSelectN), .dacWriteN(dacWriteN),
        .dacLoadStrobeN(dacLoadStrobeN), .latchClearN(latchClearN),
        .nibbleSelectFirst(nibbleSelectFirst),
        .nibbleSelectSecond(nibbleSelectSecond), .dacDataPins(dacDataPins)
    );
    ddbpl_dac_model dac (
        .csN(dacChipSelectN), .wrN(dacWriteN), .loadN(dacLoadStrobeN),
        .clearN(latchClearN), .selFirst(nibbleSelectFirst),
        .selSecond(nibbleSelectSecond), .pins(dacDataPins),
        .inLatch(inLatch), .dacLatch(dacLatch), .holdErr(holdErr)
    );

    initial begin
        forever #25 clk_sys = ~clk_sys;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    // one idle cycle after each transfer keeps psel from being set twice
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        // no cycle count assumed: only the watchdog ends a stuck wait
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'b1);
        rd    = prdata;
        rdErr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask : apb

    task automatic run_load(input logic [31:0] ctrl, input logic [9:0] code);
        apb(1'b1, REG_CODE, {22'h0, code});
        apb(1'b1, REG_CTRL, ctrl);
        do begin
            apb(1'b0, REG_STATUS, 32'h0);
        end while (rd[STAT_DONE] !== 1'b1);
        apb(1'b1, REG_STATUS, 32'h2);
    endtask : run_load

    task automatic wrap_up;
        $display("checks=%0d errors=%0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : wrap_up

    initial begin
        repeat (20000) @(posedge clk_sys);
        num_errors++;
        wrap_up();
    end

    initial begin
        repeat (5) @(posedge clk_sys);
        srst <= 1'b0;
        @(posedge clk_sys);
        check(32'(dacLatch), 32'h0);
        apb(1'b0, REG_STATUS, 32'h0);
        check(rd, 32'h0);
        // byte/nibble orders, pulsed and transparent strobe, edge codes
        for (int i = 0; i < 4; i++) begin
            run_load(ctrlTab[i], codeTab[i]);
            check(32'(inLatch), 32'({codeTab[i], SUB_LSB_ZERO}));
            check(32'(dacLatch), 32'({codeTab[i], SUB_LSB_ZERO}));
            // done cleared, not busy, loaded code reported
            apb(1'b0, REG_STATUS, 32'h0);
            check(rd, 32'(codeTab[i]) << STAT_CODE_LSB);
        end
        apb(1'b1, REG_CODE, 32'h0aa);
        apb(1'b0, REG_STATUS, 32'h0);
        check(rd & 32'h7, 32'h0);
        check(32'(dacLatch), 32'h004);
        apb(1'b1, REG_CTRL, 32'h8);
        apb(1'b0, REG_STATUS, 32'h0);
        check(32'(latchClearN), 32'h0);
        check(32'(dacLatch), 32'h0);
        run_load(32'hb, 10'h155);
        check(32'(dacLatch), 32'h0);
        check(32'(inLatch), 32'h554);
        apb(1'b1, REG_CTRL, 32'h0);
        apb(1'b0, REG_STATUS, 32'h0);
        check(32'(dacLatch), 32'h0);
        apb(1'b0, 8'h0c, 32'h0);
        check(rd, 32'h0);
        check(32'(rdErr), 32'h1);
        check(32'(holdErr), 32'h0);
        wrap_up();
    end
endmodule : dac_double_buffered_parallel_load_tb_top

`default_nettype wire
